// ---- verilog/fcs_map.svh ----
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH
// Clock rate and auto operation times
`define FCS_CLK_MHZ 100
`define FCS_T_PROG_US 60
`define FCS_T_PROT_US 60
`define FCS_T_SERASE_MS 75
`define FCS_T_CERASE_MS 300
`define FCS_PROG_CYC (`FCS_T_PROG_US * `FCS_CLK_MHZ)
`define FCS_PROT_CYC (`FCS_T_PROT_US * `FCS_CLK_MHZ)
`define FCS_SERASE_CYC (`FCS_T_SERASE_MS * 1000 * `FCS_CLK_MHZ)
`define FCS_CERASE_CYC (`FCS_T_CERASE_MS * 1000 * `FCS_CLK_MHZ)
`define FCS_TMR_W 25
// Command offsets within the mapped flash area
`define FCS_FLASH_PAGE 12'hFE0
`define FCS_ADR_UNLOCK1 12'hAAA
`define FCS_ADR_UNLOCK2 12'h554
`define FCS_ADR_PROT 12'h77E
`define FCS_ADR_ID_VENDOR 8'h00
`define FCS_ADR_ID_MACRO 8'h02
`define FCS_ADR_ID_SIZE 8'h04
// Command data bytes
`define FCS_DAT_UNLOCK1 8'hAA
`define FCS_DAT_UNLOCK2 8'h55
`define FCS_DAT_PROG 8'hA0
`define FCS_DAT_ERASE 8'h80
`define FCS_DAT_IDENT 8'h90
`define FCS_DAT_RESET 8'hF0
`define FCS_DAT_PROT 8'hA5
`define FCS_DAT_SECT 8'h30
`define FCS_DAT_CHIP 8'h10
`define FCS_DAT_RPROT 8'hF0
`define FCS_DAT_WPROT 8'h0F
// Array layout, reset values and status bit positions
`define FCS_ARRAY_WORDS 65536
`define FCS_SECT_LAST 11'h7FF
`define FCS_ERASED_WORD 16'hFFFF
`define FCS_PROT_RESET 8'hFF
`define FCS_BIT_POLL 7
`define FCS_BIT_TOGGLE 6
`endif

// ---- verilog/fcs_pkg.sv ----
package fcs_pkg;
   // Operations offered on the host command port
   typedef enum logic [2:0] {
      FCS_OP_READ = 3'b000,
      FCS_OP_PROG = 3'b001,
      FCS_OP_SERASE = 3'b010,
      FCS_OP_CERASE = 3'b011,
      FCS_OP_IDENT = 3'b100,
      FCS_OP_IDEXIT = 3'b101,
      FCS_OP_RPROT = 3'b110,
      FCS_OP_WPROT = 3'b111
   } fcs_op_e;
   // Device sequence decoder states
   typedef enum logic [3:0] {
      DS_IDLE = 4'b0000,
      DS_UNL1 = 4'b0001,
      DS_UNL2 = 4'b0010,
      DS_PROG = 4'b0011,
      DS_ERA1 = 4'b0100,
      DS_ERA2 = 4'b0101,
      DS_ERA3 = 4'b0110,
      DS_PROT = 4'b0111,
      DS_BUSY = 4'b1000
   } fcs_dstate_e;
   // Running auto operation
   typedef enum logic [1:0] {
      AUTO_PROG = 2'b00,
      AUTO_SERASE = 2'b01,
      AUTO_CERASE = 2'b10,
      AUTO_PROT = 2'b11
   } fcs_auto_e;
   // Host sequencer states
   typedef enum logic [2:0] {
      HS_IDLE = 3'b000,
      HS_WR = 3'b001,
      HS_WACK = 3'b010,
      HS_RD = 3'b011,
      HS_RACK = 3'b100
   } fcs_hstate_e;
endpackage: fcs_pkg

// ---- verilog/fcs_if.sv ----
`timescale 1ns/1ns
// Processor bus into the flash area
interface fcs_if (
   input wire logic clk,
   input wire logic rst
);
   logic bus_req;
   logic bus_we;
   logic bus_word;
   logic [23:0] bus_addr;
   logic [15:0] bus_wdata;
   logic bus_ack;
   logic [15:0] bus_rdata;
   modport dev (
      input clk, rst, bus_req, bus_we, bus_word, bus_addr, bus_wdata,
      output bus_ack, bus_rdata
   );
   modport host (
      input clk, rst, bus_ack, bus_rdata,
      output bus_req, bus_we, bus_word, bus_addr, bus_wdata
   );
endinterface: fcs_if

// ---- verilog/fcs_timer.sv ----
`timescale 1ns/1ns
`include "fcs_map.svh"
// Down counter timing one auto operation
module fcs_timer (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [`FCS_TMR_W-1:0] count,
   output logic busy
);
   logic [`FCS_TMR_W-1:0] cnt_r;

   // Load on start, count down to zero
   always_ff @(posedge clk)
   begin
      if (rst)
         cnt_r <= '0;
      else if (load)
         cnt_r <= count;
      else if (cnt_r != '0)
         cnt_r <= cnt_r - `FCS_TMR_W'(1);
   end

   assign busy = (cnt_r != '0);
endmodule: fcs_timer

// ---- verilog/fcs_device.sv ----
`timescale 1ns/1ns
`include "fcs_map.svh"
////////////////////////////////////////////////////////////////////////
module fcs_device
   import fcs_pkg::*;
#(
   parameter int unsigned PROG_CYC = `FCS_PROG_CYC,
   parameter int unsigned PROT_CYC = `FCS_PROT_CYC,
   parameter int unsigned SERASE_CYC = `FCS_SERASE_CYC,
   parameter int unsigned CERASE_CYC = `FCS_CERASE_CYC,
   parameter logic [7:0] VENDOR_ID = 8'h5A, // Arbitrary value
   parameter logic [7:0] MACRO_ID = 8'h3C, // Arbitrary value
   parameter logic [7:0] SIZE_ID = 8'h11 // Arbitrary value
)
(
   fcs_if.dev bus,
   input wire logic prog_mode,
   output logic auto_busy,
   output logic ident_mode,
   output logic read_protected,
   output logic write_protected
);
   logic [15:0] mem [0:`FCS_ARRAY_WORDS-1];
   fcs_dstate_e st_r;
   fcs_auto_e op_r;
   logic [15:0] pa_r;
   logic [15:0] pd_r;
   logic [7:0] prot_r;
   logic tog_r;
   logic pm_meta_r;
   logic pm_sync_r;
   logic era_run_r;
   logic [15:0] era_ptr_r;
   logic [15:0] era_end_r;
   logic wr;
   logic rd;
   logic [11:0] cadr;
   logic [7:0] cdat;
   logic a_unl1;
   logic a_unl2;
   logic go_prog;
   logic go_sera;
   logic go_cera;
   logic go_prot;
   logic go_any;
   logic tmr_busy;
   logic op_done;
   logic [`FCS_TMR_W-1:0] tmr_count;
   logic [15:0] word_q;
   logic [15:0] rd_val;

   ////////////////////////////////////////////////////////////////////
   // Bus decode; command offsets use the low address bits
   assign wr = bus.bus_req & bus.bus_we;
   assign rd = bus.bus_req & ~bus.bus_we;
   assign cadr = bus.bus_addr[11:0];
   assign cdat = bus.bus_wdata[7:0];
   assign a_unl1 = (cadr == `FCS_ADR_UNLOCK1);
   assign a_unl2 = (cadr == `FCS_ADR_UNLOCK2);

   // Final writes that launch an auto operation
   assign go_prog = wr && st_r == DS_PROG;
   assign go_sera = wr && st_r == DS_ERA3 && cdat == `FCS_DAT_SECT
      && !pm_sync_r;
   assign go_cera = wr && st_r == DS_ERA3 && a_unl1
      && cdat == `FCS_DAT_CHIP;
   assign go_prot = wr && st_r == DS_PROT && cadr == `FCS_ADR_PROT
      && (cdat == `FCS_DAT_RPROT || cdat == `FCS_DAT_WPROT);
   assign go_any = go_prog | go_sera | go_cera | go_prot;
   assign op_done = (st_r == DS_BUSY) && !tmr_busy && !era_run_r;

   // Programmer mode strap crosses in through two flops
   always_ff @(posedge bus.clk)
   begin
      pm_meta_r <= prog_mode;
      pm_sync_r <= pm_meta_r;
   end

   ////////////////////////////////////////////////////////////////////
   // Unlock sequence decoder
   always_ff @(posedge bus.clk)
   begin
      if (bus.rst)
         st_r <= DS_IDLE;
      else if (op_done)
         st_r <= DS_IDLE;
      else if (go_any)
         st_r <= DS_BUSY;
      else if (wr)
      begin
         unique case (st_r)
            DS_IDLE: st_r <= (a_unl1 && cdat == `FCS_DAT_UNLOCK1)
               ? DS_UNL1 : DS_IDLE;
            DS_UNL1: st_r <= (a_unl2 && cdat == `FCS_DAT_UNLOCK2)
               ? DS_UNL2 : DS_IDLE;
            DS_UNL2:
            begin
               if (a_unl1 && cdat == `FCS_DAT_PROG)
                  st_r <= DS_PROG;
               else if (a_unl1 && cdat == `FCS_DAT_ERASE)
                  st_r <= DS_ERA1;
               else if (a_unl1 && cdat == `FCS_DAT_PROT)
                  st_r <= DS_PROT;
               else
                  st_r <= DS_IDLE;
            end
            DS_ERA1: st_r <= (a_unl1 && cdat == `FCS_DAT_UNLOCK1)
               ? DS_ERA2 : DS_IDLE;
            DS_ERA2: st_r <= (a_unl2 && cdat == `FCS_DAT_UNLOCK2)
               ? DS_ERA3 : DS_IDLE;
            DS_ERA3: st_r <= DS_IDLE;
            DS_PROT: st_r <= DS_IDLE;
            DS_BUSY: st_r <= DS_BUSY;
            default: st_r <= DS_IDLE;
         endcase
      end
   end

   // Identification mode entry and exit
   always_ff @(posedge bus.clk)
   begin
      if (bus.rst)
         ident_mode <= 1'b0;
      else if (wr && st_r == DS_UNL2 && a_unl1)
      begin
         if (cdat == `FCS_DAT_IDENT)
            ident_mode <= 1'b1;
         else if (cdat == `FCS_DAT_RESET)
            ident_mode <= 1'b0;
      end
      else if (wr && st_r == DS_IDLE && cdat == `FCS_DAT_RESET)
         ident_mode <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // Capture the operation, its word address and data
   always_ff @(posedge bus.clk)
   begin
      if (bus.rst)
         op_r <= AUTO_PROG;
      else if (go_prog)
      begin
         op_r <= AUTO_PROG;
         pa_r <= bus.bus_addr[16:1];
         pd_r <= bus.bus_wdata;
      end
      else if (go_sera)
         op_r <= AUTO_SERASE;
      else if (go_cera)
         op_r <= AUTO_CERASE;
      else if (go_prot)
      begin
         op_r <= AUTO_PROT;
         pd_r <= {8'h00, cdat};
      end
   end

   // Duration of the launched operation; one less, as leaving busy
   // takes a cycle of its own
   always_comb
   begin
      tmr_count = `FCS_TMR_W'(PROG_CYC - 1);
      if (go_sera)
         tmr_count = `FCS_TMR_W'(SERASE_CYC - 1);
      else if (go_cera)
         tmr_count = `FCS_TMR_W'(CERASE_CYC - 1);
      else if (go_prot)
         tmr_count = `FCS_TMR_W'(PROT_CYC - 1);
   end

   fcs_timer u_timer (
      .clk(bus.clk),
      .rst(bus.rst),
      .load(go_any),
      .count(tmr_count),
      .busy(tmr_busy)
   );

   // Erase walker clears one word per cycle over the range
   always_ff @(posedge bus.clk)
   begin
      if (bus.rst)
      begin
         era_run_r <= 1'b0;
         era_ptr_r <= 16'h0000;
         era_end_r <= 16'h0000;
      end
      else if (go_sera)
      begin
         era_run_r <= 1'b1;
         era_ptr_r <= {bus.bus_addr[16:12], 11'h000};
         era_end_r <= {bus.bus_addr[16:12], `FCS_SECT_LAST};
      end
      else if (go_cera)
      begin
         era_run_r <= 1'b1;
         era_ptr_r <= 16'h0000;
         era_end_r <= 16'hFFFF;
      end
      else if (era_run_r && era_ptr_r == era_end_r)
         era_run_r <= 1'b0;
      else if (era_run_r)
         era_ptr_r <= era_ptr_r + 16'h0001;
   end

   // Array updates: erase to ones, program can only clear bits
   always_ff @(posedge bus.clk)
   begin
      if (era_run_r)
         mem[era_ptr_r] <= `FCS_ERASED_WORD;
      else if (op_done && op_r == AUTO_PROG)
         mem[pa_r] <= mem[pa_r] & pd_r;
   end

   // Protection status byte; chip erase lifts protection
   always_ff @(posedge bus.clk)
   begin
      if (bus.rst)
         prot_r <= `FCS_PROT_RESET;
      else if (op_done && op_r == AUTO_CERASE)
         prot_r <= `FCS_PROT_RESET;
      else if (op_done && op_r == AUTO_PROT)
         prot_r <= prot_r & ~pd_r[7:0];
   end

   ////////////////////////////////////////////////////////////////////
   // Toggle bit starts at one and flips on every busy read
   always_ff @(posedge bus.clk)
   begin
      if (bus.rst)
         tog_r <= 1'b1;
      else if (go_any)
         tog_r <= 1'b1;
      else if (rd && st_r == DS_BUSY)
         tog_r <= ~tog_r;
   end

   // Read data selection
   always_comb
   begin
      word_q = mem[bus.bus_addr[16:1]];
      rd_val = 16'h0000;
      if (st_r == DS_BUSY)
      begin
         rd_val[`FCS_BIT_TOGGLE] = tog_r;
         if (op_r == AUTO_PROG)
            rd_val[`FCS_BIT_POLL] = (bus.bus_addr[0] && !bus.bus_word)
               ? ~pd_r[15] : ~pd_r[7];
      end
      else if (ident_mode)
      begin
         if (cadr == `FCS_ADR_PROT)
            rd_val[7:0] = prot_r;
         else if (bus.bus_addr[7:0] == `FCS_ADR_ID_VENDOR)
            rd_val[7:0] = VENDOR_ID;
         else if (bus.bus_addr[7:0] == `FCS_ADR_ID_MACRO)
            rd_val[7:0] = MACRO_ID;
         else if (bus.bus_addr[7:0] == `FCS_ADR_ID_SIZE)
            rd_val[7:0] = SIZE_ID;
      end
      else if (bus.bus_word)
         rd_val = word_q;
      else
         rd_val[7:0] = bus.bus_addr[0] ? word_q[15:8] : word_q[7:0];
   end

   // Bus answer one cycle after each request
   always_ff @(posedge bus.clk)
   begin
      if (bus.rst)
      begin
         bus.bus_ack <= 1'b0;
         bus.bus_rdata <= 16'h0000;
      end
      else
      begin
         bus.bus_ack <= bus.bus_req;
         if (rd)
            bus.bus_rdata <= rd_val;
      end
   end

   // Status outputs
   always_ff @(posedge bus.clk)
   begin
      if (bus.rst)
      begin
         auto_busy <= 1'b0;
         read_protected <= 1'b0;
         write_protected <= 1'b0;
      end
      else
      begin
         auto_busy <= go_any | (auto_busy & ~op_done);
         read_protected <= (prot_r[7:4] != 4'hF);
         write_protected <= (prot_r[3:0] != 4'hF);
      end
   end
endmodule: fcs_device

// ---- verilog/fcs_host.sv ----
`timescale 1ns/1ns
`include "fcs_map.svh"
// Processor-side command issuer for the flash sequencer
module fcs_host
   import fcs_pkg::*;
(
   fcs_if.host bus,
   input wire logic cmd_valid,
   input wire fcs_op_e cmd_op,
   input wire logic [23:0] cmd_addr,
   input wire logic [15:0] cmd_data,
   input wire logic cmd_word,
   output logic cmd_ready,
   output logic cmd_done,
   output logic [15:0] rsp_data
);
   fcs_hstate_e hs_r;
   fcs_op_e op_r;
   logic [2:0] step_r;
   logic [23:0] adr_r;
   logic [15:0] dat_r;
   logic word_r;
   logic poll_r;
   logic have_r;
   logic [15:0] prev_r;
   logic is_auto;
   logic [23:0] poll_adr;

   // Address and data of write step s of a sequence
   function automatic logic [39:0] seq_item(input fcs_op_e op,
      input logic [2:0] s, input logic [23:0] a, input logic [15:0] d);
      logic [23:0] u1;
      logic [23:0] u2;
      logic [7:0] third;
      u1 = {`FCS_FLASH_PAGE, `FCS_ADR_UNLOCK1};
      u2 = {`FCS_FLASH_PAGE, `FCS_ADR_UNLOCK2};
      third = `FCS_DAT_PROT;
      if (op == FCS_OP_PROG)
         third = `FCS_DAT_PROG;
      else if (op == FCS_OP_SERASE || op == FCS_OP_CERASE)
         third = `FCS_DAT_ERASE;
      else if (op == FCS_OP_IDENT)
         third = `FCS_DAT_IDENT;
      seq_item = {u1, 8'h00, `FCS_DAT_UNLOCK1};
      unique case (s)
         3'd0: if (op == FCS_OP_IDEXIT)
            seq_item = {a, 8'h00, `FCS_DAT_RESET};
         3'd1: seq_item = {u2, 8'h00, `FCS_DAT_UNLOCK2};
         3'd2: seq_item = {u1, 8'h00, third};
         3'd3: if (op == FCS_OP_PROG)
            seq_item = {a[23:1], 1'b0, d};
         else if (op == FCS_OP_RPROT)
            seq_item = {`FCS_FLASH_PAGE, `FCS_ADR_PROT, 8'h00,
               `FCS_DAT_RPROT};
         else if (op == FCS_OP_WPROT)
            seq_item = {`FCS_FLASH_PAGE, `FCS_ADR_PROT, 8'h00,
               `FCS_DAT_WPROT};
         3'd4: seq_item = {u2, 8'h00, `FCS_DAT_UNLOCK2};
         3'd5: if (op == FCS_OP_SERASE)
            seq_item = {a, 8'h00, `FCS_DAT_SECT};
         else
            seq_item = {u1, 8'h00, `FCS_DAT_CHIP};
         default: seq_item = {u1, 8'h00, `FCS_DAT_UNLOCK1};
      endcase
   endfunction: seq_item

   // Index of the final write of a sequence
   function automatic logic [2:0] seq_last(input fcs_op_e op);
      unique case (op)
         FCS_OP_PROG, FCS_OP_RPROT, FCS_OP_WPROT: seq_last = 3'd3;
         FCS_OP_SERASE, FCS_OP_CERASE: seq_last = 3'd5;
         FCS_OP_IDENT: seq_last = 3'd2;
         FCS_OP_READ, FCS_OP_IDEXIT: seq_last = 3'd0;
      endcase
   endfunction: seq_last

   assign is_auto = (op_r == FCS_OP_PROG) || (op_r == FCS_OP_SERASE)
      || (op_r == FCS_OP_CERASE) || (op_r == FCS_OP_RPROT)
      || (op_r == FCS_OP_WPROT);
   assign poll_adr = (op_r == FCS_OP_RPROT || op_r == FCS_OP_WPROT)
      ? {`FCS_FLASH_PAGE, `FCS_ADR_PROT}
      : {adr_r[23:1], adr_r[0] & ~poll_r};

   ////////////////////////////////////////////////////////////////////
   // Command sequencer, bus driver and completion polling
   always_ff @(posedge bus.clk)
   begin
      if (bus.rst)
      begin
         hs_r <= HS_IDLE;
         op_r <= FCS_OP_READ;
         step_r <= 3'd0;
         adr_r <= 24'h000000;
         dat_r <= 16'h0000;
         word_r <= 1'b0;
         poll_r <= 1'b0;
         have_r <= 1'b0;
         prev_r <= 16'h0000;
         cmd_ready <= 1'b0;
         cmd_done <= 1'b0;
         rsp_data <= 16'h0000;
         bus.bus_req <= 1'b0;
         bus.bus_we <= 1'b0;
         bus.bus_word <= 1'b0;
         bus.bus_addr <= 24'h000000;
         bus.bus_wdata <= 16'h0000;
      end
      else
      begin
         bus.bus_req <= 1'b0;
         cmd_done <= 1'b0;
         unique case (hs_r)
            HS_IDLE:
            begin
               cmd_ready <= 1'b1;
               if (cmd_valid && cmd_ready)
               begin
                  cmd_ready <= 1'b0;
                  op_r <= cmd_op;
                  adr_r <= cmd_addr;
                  dat_r <= cmd_data;
                  word_r <= cmd_word;
                  step_r <= 3'd0;
                  poll_r <= 1'b0;
                  have_r <= 1'b0;
                  hs_r <= (cmd_op == FCS_OP_READ) ? HS_RD : HS_WR;
               end
            end
            HS_WR:
            begin
               {bus.bus_addr, bus.bus_wdata} <=
                  seq_item(op_r, step_r, adr_r, dat_r);
               bus.bus_req <= 1'b1;
               bus.bus_we <= 1'b1;
               bus.bus_word <= 1'b1;
               hs_r <= HS_WACK;
            end
            HS_WACK: if (bus.bus_ack)
            begin
               if (step_r != seq_last(op_r))
               begin
                  step_r <= step_r + 3'd1;
                  hs_r <= HS_WR;
               end
               else if (is_auto)
               begin
                  poll_r <= 1'b1;
                  hs_r <= HS_RD;
               end
               else
               begin
                  cmd_done <= 1'b1;
                  hs_r <= HS_IDLE;
               end
            end
            HS_RD:
            begin
               bus.bus_addr <= poll_adr;
               bus.bus_req <= 1'b1;
               bus.bus_we <= 1'b0;
               bus.bus_word <= poll_r | word_r;
               hs_r <= HS_RACK;
            end
            HS_RACK: if (bus.bus_ack)
            begin
               if (!poll_r || (have_r && bus.bus_rdata == prev_r))
               begin
                  rsp_data <= bus.bus_rdata;
                  cmd_done <= 1'b1;
                  hs_r <= HS_IDLE;
               end
               else
               begin
                  prev_r <= bus.bus_rdata;
                  have_r <= 1'b1;
                  hs_r <= HS_RD;
               end
            end
            default: hs_r <= HS_IDLE;
         endcase
      end
   end
endmodule: fcs_host

// ---- tb/fcs_chk_sva.sv ----
`timescale 1ns/1ns
`include "fcs_map.svh"
////////////////////////////////////////////////////////////////////////
// Wire checks between the host and device ends
module fcs_chk_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic bus_req,
   input wire logic bus_we,
   input wire logic bus_word,
   input wire logic [23:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic bus_ack,
   input wire logic [15:0] bus_rdata
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   logic wr;
   logic rd;
   logic [11:0] ofs;
   logic [7:0] cmd;
   // Request kinds and command fields
   assign wr = bus_req && bus_we;
   assign rd = bus_req && !bus_we;
   assign ofs = bus_addr[11:0];
   assign cmd = bus_wdata[7:0];
   ////////////////////////////////////////////////////////////////////
   a_ack_follows_req: assert property (bus_req |=> bus_ack)
      else $error("ack missing after request");
   a_ack_has_req: assert property (bus_ack |-> $past(bus_req))
      else $error("ack without request");
   a_rdata_holds: assert property (
      !(bus_ack && !$past(bus_we)) |-> $stable(bus_rdata))
      else $error("read data moved without a read answer");
   a_unlock_second: assert property (
      wr && ofs == `FCS_ADR_UNLOCK1 && cmd == `FCS_DAT_UNLOCK1 |->
      ##[1:6] (wr && ofs == `FCS_ADR_UNLOCK2 && cmd == `FCS_DAT_UNLOCK2))
      else $error("second unlock write missing");
   a_unlock_third: assert property (
      wr && ofs == `FCS_ADR_UNLOCK2 && cmd == `FCS_DAT_UNLOCK2 |->
      ##[1:6] (wr && (ofs == `FCS_ADR_UNLOCK1 || cmd == `FCS_DAT_SECT)))
      else $error("third write misplaced");
   a_prot_target: assert property (
      wr && ofs == `FCS_ADR_UNLOCK1 && cmd == `FCS_DAT_PROT |->
      ##[1:6] (wr && ofs == `FCS_ADR_PROT &&
      (cmd == `FCS_DAT_RPROT || cmd == `FCS_DAT_WPROT)))
      else $error("protect write misplaced");
   a_addr_mapped: assert property (bus_req |-> &bus_addr[23:17])
      else $error("address outside flash area");
   a_prog_even: assert property (
      wr && ofs == `FCS_ADR_UNLOCK1 && cmd == `FCS_DAT_PROG |->
      ##[1:6] (wr && !bus_addr[0]))
      else $error("odd program address");
   a_poll_after: assert property (
      (wr && ofs == `FCS_ADR_UNLOCK1 && cmd == `FCS_DAT_PROG) ##[1:6] wr
      |-> ##[1:6] rd)
      else $error("no poll read after program");
endmodule: fcs_chk_sva

// ---- tb/flash_command_sequencer_tb_top.sv ----
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////
// Host and device joined back to back, driven from the command port
module flash_command_sequencer_tb_top
   import fcs_pkg::*;
();
   localparam int AUTO_N = 20;
   localparam int ERASE_N = 40;
   logic clk;
   logic rst;
   logic cmd_valid;
   fcs_op_e cmd_op;
   logic [23:0] cmd_addr;
   logic [15:0] cmd_data;
   logic cmd_word;
   logic cmd_ready;
   logic cmd_done;
   logic [15:0] rsp_data;
   logic prog_mode;
   logic auto_busy;
   logic ident_mode;
   logic read_protected;
   logic write_protected;
   logic busy_seen;
   int cycles;
   int error_cnt;
   int check_count;
   fcs_if u_fcs_if (.clk(clk), .rst(rst));
   fcs_device #(.PROG_CYC(AUTO_N), .PROT_CYC(AUTO_N),
      .SERASE_CYC(ERASE_N), .CERASE_CYC(ERASE_N)) u_fcs_device (
      .bus(u_fcs_if), .prog_mode(prog_mode), .auto_busy(auto_busy),
      .ident_mode(ident_mode), .read_protected(read_protected),
      .write_protected(write_protected));
   fcs_host u_fcs_host (.bus(u_fcs_if), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .cmd_word(cmd_word), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
      .rsp_data(rsp_data));
   fcs_chk_sva u_fcs_chk_sva (.clk(clk), .rst(rst),
      .bus_req(u_fcs_if.bus_req), .bus_we(u_fcs_if.bus_we),
      .bus_word(u_fcs_if.bus_word), .bus_addr(u_fcs_if.bus_addr),
      .bus_wdata(u_fcs_if.bus_wdata), .bus_ack(u_fcs_if.bus_ack),
      .bus_rdata(u_fcs_if.bus_rdata));
   ////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask: end_sim
   // Data and flag comparisons
   task automatic chk_data(input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: exp %h got %h", $time, exp, got);
      end
   endtask: chk_data
   task automatic chk_flag(input logic exp, input logic got);
      chk_data({15'h0000, exp}, {15'h0000, got});
   endtask: chk_flag
   // One command through the host, bounded waits on ready and done
   task automatic do_cmd(input fcs_op_e op, input logic [23:0] a,
      input logic [15:0] d, input logic w);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 50)
      begin
         @(negedge clk);
         n++;
      end
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      cmd_word = w;
      cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
      busy_seen = 1'b0;
      cycles = 0;
      while (cmd_done !== 1'b1 && cycles < 80000)
      begin
         @(negedge clk);
         cycles++;
         if (auto_busy === 1'b1)
            busy_seen = 1'b1;
      end
      if (n == 50 || cycles == 80000)
      begin
         error_cnt++;
         end_sim();
      end
   endtask: do_cmd
   // Array read through the host and compare
   task automatic rd(input logic [23:0] a, input logic w,
      input logic [15:0] exp);
      do_cmd(FCS_OP_READ, a, 16'h0000, w);
      chk_data(exp, rsp_data);
   endtask: rd
   ////////////////////////////////////////////////////////////////////
   // Whole array erased to ones
   task automatic t_chip_erase;
      do_cmd(FCS_OP_CERASE, 24'hFE0000, 16'h0000, 1'b1);
      chk_flag(1'b1, busy_seen);
      rd(24'hFE0000, 1'b1, 16'hFFFF);
      rd(24'hFFFFFE, 1'b1, 16'hFFFF);
      rd(24'hFE8001, 1'b0, 16'h00FF);
      $display("test chip_erase done");
   endtask: t_chip_erase
   // Word program, odd address folded to even
   task automatic t_program;
      do_cmd(FCS_OP_PROG, 24'hFE0010, 16'h1234, 1'b1);
      chk_flag(1'b1, busy_seen);
      chk_flag(1'b1, cycles <= 6000);
      rd(24'hFE0010, 1'b1, 16'h1234);
      rd(24'hFE0011, 1'b0, 16'h0012);
      do_cmd(FCS_OP_PROG, 24'hFE0021, 16'hABCD, 1'b1);
      rd(24'hFE0020, 1'b1, 16'hABCD);
      $display("test program done");
   endtask: t_program
   // Sector erase hits one sector only, refused in programmer mode
   task automatic t_sector;
      do_cmd(FCS_OP_PROG, 24'hFE1000, 16'h0000, 1'b1);
      do_cmd(FCS_OP_PROG, 24'hFE1FFE, 16'h0000, 1'b1);
      do_cmd(FCS_OP_SERASE, 24'hFE1002, 16'h0000, 1'b1);
      chk_flag(1'b1, busy_seen);
      rd(24'hFE1000, 1'b1, 16'hFFFF);
      rd(24'hFE1FFE, 1'b1, 16'hFFFF);
      rd(24'hFE0010, 1'b1, 16'h1234);
      do_cmd(FCS_OP_PROG, 24'hFE1004, 16'h5555, 1'b1);
      prog_mode = 1'b1;
      repeat (3) @(negedge clk);
      do_cmd(FCS_OP_SERASE, 24'hFE1004, 16'h0000, 1'b1);
      chk_flag(1'b0, busy_seen);
      rd(24'hFE1004, 1'b1, 16'h5555);
      prog_mode = 1'b0;
      $display("test sector_erase done");
   endtask: t_sector
   // Identification entry, reads and exit
   task automatic t_ident;
      do_cmd(FCS_OP_IDENT, 24'hFE0000, 16'h0000, 1'b1);
      chk_flag(1'b1, ident_mode);
      rd(24'hFE0000, 1'b0, 16'h005A);
      rd(24'hFE0002, 1'b0, 16'h003C);
      rd(24'hFE0004, 1'b0, 16'h0011);
      rd(24'hFE0010, 1'b1, 16'h0000);
      rd(24'hFE077E, 1'b0, 16'h00FF);
      do_cmd(FCS_OP_IDEXIT, 24'hFE0000, 16'h0000, 1'b1);
      chk_flag(1'b0, ident_mode);
      rd(24'hFE0010, 1'b1, 16'h1234);
      $display("test ident done");
   endtask: t_ident
   // Read then write protection set
   task automatic t_protect;
      do_cmd(FCS_OP_RPROT, 24'hFE077E, 16'h0000, 1'b1);
      chk_flag(1'b1, busy_seen);
      chk_flag(1'b1, cycles <= 6000);
      chk_flag(1'b1, read_protected);
      chk_flag(1'b0, write_protected);
      do_cmd(FCS_OP_WPROT, 24'hFE077E, 16'h0000, 1'b1);
      chk_flag(1'b1, write_protected);
      do_cmd(FCS_OP_IDENT, 24'hFE0000, 16'h0000, 1'b1);
      rd(24'hFE077E, 1'b0, 16'h0000);
      do_cmd(FCS_OP_IDEXIT, 24'hFE0000, 16'h0000, 1'b1);
      $display("test protect done");
   endtask: t_protect
   ////////////////////////////////////////////////////////////////////
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Reset, then the scenarios in order
   initial
   begin
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = FCS_OP_READ;
      cmd_addr = 24'hFE0000;
      cmd_data = 16'h0000;
      cmd_word = 1'b1;
      prog_mode = 1'b0;
      error_cnt = 0;
      check_count = 0;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      t_chip_erase();
      t_program();
      t_sector();
      t_ident();
      t_protect();
      end_sim();
   end
endmodule: flash_command_sequencer_tb_top
